// file: pkg/shrp_cfg.svh
`ifndef SHRP_CFG_SVH
`define SHRP_CFG_SVH

// ==========================================================
// Address/command byte layout
`define SHRP_AC_W          8
`define SHRP_AC_KIND_HI    7
`define SHRP_AC_KIND_LO    6
`define SHRP_AC_LEN_HI     5
`define SHRP_AC_LEN_LO     4
`define SHRP_KIND_CMD      2'h0
`define SHRP_KIND_WRITE    2'h1
`define SHRP_KIND_READ     2'h2

// ==========================================================
// Framing and buffering
`define SHRP_BITS_PER_BYTE 3'h7
`define SHRP_FIFO_W        16
`define SHRP_FIFO_D        8

`endif

// file: pkg/shrp_pkg.sv
package shrp_pkg;

  // ==========================================================
  // Transfer phases
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_AC,
    ST_WRITE,
    ST_READ,
    ST_DONE
  } shrp_state_t;

endpackage : shrp_pkg

// file: design/shrp_port.sv
// Operation
// (R1) Each transaction: one address/command byte, then optional write or read bytes.
// (R2) Command data input is sampled on every serial clock rising edge; the code samples it only in the A/C and write phases.
// (R3) Reply bit changes on falling edges so it is stable while clock high; the code drives the first bit just after the last A/C rising edge.
// (R4) Host holds chip select low for a transfer, high between transfers.
// (R5) Data byte count and direction come from the address/command byte.
// (R6) All bytes shift most significant bit first, both directions.
// (R7) Command-only transaction carries exactly eight bits, no data phase.
// (R8) Each single data byte carries exactly eight bits.
// (R9) Address byte sets direction; input and reply never both active.
// (R10) Serial clock may rest high or low at start and end.
// (R11) Gaps between bytes are optional; back-to-back bytes accepted.
// (R12) Reply output is released whenever no read data is being sent.
// (R13) Chip select release abandons partial bytes; next transfer restarts.
`timescale 1ns/100ps
`include "shrp_cfg.svh"

// ==========================================================
// Write-data FIFO
module shrp_fifo #(
  parameter int W = `SHRP_FIFO_W,
  parameter int D = `SHRP_FIFO_D
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic         s_valid,
  output logic              s_ready,
  input  wire logic [W-1:0] s_data,
  output logic              m_valid,
  input  wire logic         m_ready,
  output logic [W-1:0]      m_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic [AW-1:0] wp_nxt;
  logic [AW-1:0] rp_nxt;
  logic [AW:0]   cnt_nxt;
  logic          push;
  logic          pop;

  assign s_ready = (cnt_r != (AW+1)'(D));
  assign m_valid = (cnt_r != '0);
  assign m_data  = mem_r[rp_r];

  always_comb begin
    push    = s_valid & s_ready;
    pop     = m_valid & m_ready;
    wp_nxt  = push ? ((wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt  = pop ? ((rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage has no reset; only entries counted valid are ever read
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wp_r] <= s_data;
    end
  end
endmodule : shrp_fifo

// ==========================================================
// Serial host register port, device end
module shrp_port (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       sclk,
  input  wire logic       chip_select_n,
  input  wire logic       command_data_in,
  output logic            reply_data_o,
  output logic            reply_data_oe_n,
  output logic            cmd_valid,
  output logic [7:0]      cmd_code,
  output logic [7:0]      rd_addr,
  output logic [1:0]      rd_index,
  input  wire logic [7:0] rd_data,
  output logic            wr_valid,
  input  wire logic       wr_ready,
  output logic [15:0]     wr_data,
  output logic            wr_overflow
);
  // ==========================================================
  // Pin synchronisers
  logic [2:0] sclk_r;
  logic [1:0] cs_r;
  logic [1:0] cdi_r;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       active;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sclk_r <= 3'h0;
      cs_r   <= 2'h3;
      cdi_r  <= 2'h0;
    end else begin
      sclk_r <= {sclk_r[1:0], sclk};
      cs_r   <= {cs_r[0], chip_select_n};
      cdi_r  <= {cdi_r[0], command_data_in};
    end
  end

  // Edges only, so the resting clock level never matters [R10]
  assign sclk_rise = sclk_r[1] & ~sclk_r[2];
  assign sclk_fall = ~sclk_r[1] & sclk_r[2];
  assign active    = ~cs_r[1];

  // ==========================================================
  // Transfer engine
  shrp_pkg::shrp_state_t st_r;
  shrp_pkg::shrp_state_t st_nxt;
  logic [2:0]  bit_r;
  logic [2:0]  bit_nxt;
  logic [1:0]  nbyte_r;
  logic [1:0]  nbyte_nxt;
  logic [1:0]  last_r;
  logic [1:0]  last_nxt;
  logic [7:0]  sh_r;
  logic [7:0]  sh_nxt;
  logic [7:0]  ac_r;
  logic [7:0]  ac_nxt;
  logic        ld_r;
  logic        ld_nxt;
  logic        skip_r;
  logic        skip_nxt;
  logic        rld_r;
  logic        rld_nxt;
  logic        oe_n_r;
  logic        oe_n_nxt;
  logic        rdo_r;
  logic        rdo_nxt;
  logic        cmdv_r;
  logic        cmdv_nxt;
  logic        ovf_r;
  logic        ovf_nxt;
  logic [1:0]  idx_r;
  logic [1:0]  idx_nxt;
  logic        push;
  logic        f_ready;
  logic [7:0]  byte_in;

  assign byte_in = {sh_r[6:0], cdi_r[1]};  // [R6]

  always_comb begin
    st_nxt    = st_r;
    bit_nxt   = bit_r;
    nbyte_nxt = nbyte_r;
    last_nxt  = last_r;
    sh_nxt    = sh_r;
    ac_nxt    = ac_r;
    ld_nxt    = 1'b0;
    skip_nxt  = skip_r;
    rld_nxt   = rld_r;
    oe_n_nxt  = oe_n_r;
    cmdv_nxt  = 1'b0;
    ovf_nxt   = ovf_r;
    idx_nxt   = idx_r;
    push      = 1'b0;
    if (!active) begin
      // Partial byte dropped; next frame starts at a fresh A/C [R13] [R4]
      st_nxt   = shrp_pkg::ST_IDLE;
      rld_nxt  = 1'b0;
      oe_n_nxt = 1'b1;  // [R12]
    end else begin
      case (st_r)
        shrp_pkg::ST_IDLE: begin
          st_nxt    = shrp_pkg::ST_AC;  // [R1]
          bit_nxt   = 3'h0;
          nbyte_nxt = 2'h0;
          skip_nxt  = 1'b0;
          ovf_nxt   = 1'b0;
        end
        shrp_pkg::ST_AC: begin
          if (sclk_rise) begin
            sh_nxt  = byte_in;  // [R2]
            bit_nxt = bit_r + 3'h1;
            if (bit_r == `SHRP_BITS_PER_BYTE) begin
              ac_nxt   = byte_in;
              cmdv_nxt = 1'b1;
              last_nxt = byte_in[`SHRP_AC_LEN_HI:`SHRP_AC_LEN_LO];  // [R5]
              idx_nxt  = 2'h0;
              case (byte_in[`SHRP_AC_KIND_HI:`SHRP_AC_KIND_LO])  // [R9]
                `SHRP_KIND_WRITE: st_nxt = shrp_pkg::ST_WRITE;
                `SHRP_KIND_READ: begin
                  st_nxt = shrp_pkg::ST_READ;
                  ld_nxt = 1'b1;
                end
                default: st_nxt = shrp_pkg::ST_DONE;  // [R7]
              endcase
            end
          end
        end
        shrp_pkg::ST_WRITE: begin
          if (sclk_rise) begin
            sh_nxt  = byte_in;  // [R2]
            bit_nxt = bit_r + 3'h1;
            if (bit_r == `SHRP_BITS_PER_BYTE) begin  // [R8]
              push      = 1'b1;
              // Host cannot be stalled, so a full FIFO loses the byte
              ovf_nxt   = ovf_r | ~f_ready;
              nbyte_nxt = nbyte_r + 2'h1;
              if (nbyte_r == last_r) begin
                st_nxt = shrp_pkg::ST_DONE;
              end
            end
          end
        end
        shrp_pkg::ST_READ: begin
          oe_n_nxt = 1'b0;  // [R9]
          if (ld_r) begin
            sh_nxt   = rd_data;  // [R6]
            skip_nxt = 1'b1;
          end else if (sclk_fall) begin
            // Change on fall, stable through the high phase [R3]
            if (rld_r) begin
              // Next byte enters on the fall, never inside a high phase
              sh_nxt  = rd_data;  // [R11]
              rld_nxt = 1'b0;
            end else if (skip_r) begin
              skip_nxt = 1'b0;
            end else begin
              sh_nxt = {sh_r[6:0], 1'b0};
            end
          end
          if (sclk_rise) begin
            bit_nxt = bit_r + 3'h1;
            if (bit_r == `SHRP_BITS_PER_BYTE) begin  // [R8]
              nbyte_nxt = nbyte_r + 2'h1;
              if (nbyte_r == last_r) begin
                st_nxt = shrp_pkg::ST_DONE;
              end else begin
                idx_nxt = idx_r + 2'h1;  // [R11]
                rld_nxt = 1'b1;
              end
            end
          end
        end
        shrp_pkg::ST_DONE: begin
          // Last bit stands through its high phase, freed on the fall
          if (sclk_fall) begin
            oe_n_nxt = 1'b1;  // [R12]
          end
        end
        default: st_nxt = shrp_pkg::ST_IDLE;
      endcase
    end
    rdo_nxt = sh_nxt[7];
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r    <= shrp_pkg::ST_IDLE;
      bit_r   <= 3'h0;
      nbyte_r <= 2'h0;
      last_r  <= 2'h0;
      sh_r    <= 8'h00;
      ac_r    <= 8'h00;
      ld_r    <= 1'b0;
      skip_r  <= 1'b0;
      rld_r   <= 1'b0;
      oe_n_r  <= 1'b1;
      rdo_r   <= 1'b0;
      cmdv_r  <= 1'b0;
      ovf_r   <= 1'b0;
      idx_r   <= 2'h0;
    end else begin
      st_r    <= st_nxt;
      bit_r   <= bit_nxt;
      nbyte_r <= nbyte_nxt;
      last_r  <= last_nxt;
      sh_r    <= sh_nxt;
      ac_r    <= ac_nxt;
      ld_r    <= ld_nxt;
      skip_r  <= skip_nxt;
      rld_r   <= rld_nxt;
      oe_n_r  <= oe_n_nxt;
      rdo_r   <= rdo_nxt;
      cmdv_r  <= cmdv_nxt;
      ovf_r   <= ovf_nxt;
      idx_r   <= idx_nxt;
    end
  end

  assign reply_data_o    = rdo_r;
  assign reply_data_oe_n = oe_n_r;
  assign cmd_valid       = cmdv_r;
  assign cmd_code        = ac_r;
  assign rd_addr         = ac_r;
  assign rd_index        = idx_r;
  assign wr_overflow     = ovf_r;

  // ==========================================================
  // Write bytes leave tagged with their A/C byte
  shrp_fifo #(
    .W (`SHRP_FIFO_W),
    .D (`SHRP_FIFO_D)
  ) u_wfifo (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .s_valid (push),
    .s_ready (f_ready),
    .s_data  ({ac_r, byte_in}),
    .m_valid (wr_valid),
    .m_ready (wr_ready),
    .m_data  (wr_data)
  );
endmodule : shrp_port

// file: tb/shrp_port_asserts.sv
`timescale 1ns/100ps
`include "shrp_cfg.svh"
// ========
// Port checks
module shrp_chk (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        sclk,
  input wire logic        chip_select_n,
  input wire logic        command_data_in,
  input wire logic        reply_data_o,
  input wire logic        reply_data_oe_n,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_code,
  input wire logic [7:0]  rd_addr,
  input wire logic [1:0]  rd_index,
  input wire logic [7:0]  rd_data,
  input wire logic        wr_valid,
  input wire logic        wr_ready,
  input wire logic [15:0] wr_data,
  input wire logic        wr_overflow
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic rd_k;
  assign rd_k = cmd_code[`SHRP_AC_KIND_HI:`SHRP_AC_KIND_LO] == `SHRP_KIND_READ;

  a_idle_release: assert property (chip_select_n [*6] |-> reply_data_oe_n)
    else $error("reply driven outside frame");
  a_drop_frame: assert property (chip_select_n [*4] |-> !cmd_valid)
    else $error("command outside frame");
  a_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
    else $error("command pulse too long");
  a_code_cause: assert property ($changed(cmd_code) |-> cmd_valid)
    else $error("code moved without byte");
  a_addr_match: assert property (rd_addr == cmd_code)
    else $error("read address differs");
  a_read_only: assert property (!reply_data_oe_n |-> rd_k)
    else $error("reply driven in non-read");
  a_reply_start: assert property (cmd_valid && rd_k |-> ##[1:2] !reply_data_oe_n)
    else $error("reply late");
  // Bit may move near the rise, so only the settled high phase is held
  a_reply_hold: assert property (sclk [*4] ##0 !reply_data_oe_n &&
    $past(!reply_data_oe_n, 3) |-> $stable(reply_data_o))
    else $error("reply moved with clock high");
  a_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
    else $error("write entry lost");

  c_read: cover property (cmd_valid && rd_k);
  c_pop: cover property (wr_valid && wr_ready);
  c_full: cover property ($rose(wr_overflow));
endmodule : shrp_chk

// file: tb/shrp_host.sv
`timescale 1ns/100ps
// ========
// Host end of the serial port
module shrp_host (
  output logic      sclk,
  output logic      chip_select_n,
  output logic      command_data_in,
  input  wire logic reply_data_o,
  input  wire logic reply_data_oe_n
);
  logic [39:0] rx;

  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    command_data_in = 1'b0;
  end

  // Set up while low, device takes it on the rise
  task bit_x(input logic b);
    sclk = 1'b0;
    command_data_in = b;
    #100 sclk = 1'b1;
    #90 rx = {rx[38:0], reply_data_oe_n ? 1'bz : reply_data_o};
    #10;
  endtask : bit_x

  // Select held low for the whole frame, clock rests at idle
  task frame(input logic [39:0] v, input int nb, input logic idle,
             input int gap);
    int k;
    sclk = idle;
    chip_select_n = 1'b0;
    #200;
    for (k = 0; k < nb; k++) begin
      if (k > 0 && k % 8 == 0)
        #(gap);
      bit_x(v[39-k]);
    end
    #100 sclk = idle;
    #100 chip_select_n = 1'b1;
    // Released line must not keep its last value
    command_data_in = ~command_data_in;
    #300;
  endtask : frame
endmodule : shrp_host

// file: tb/tb.sv
`timescale 1ns/100ps
`include "shrp_cfg.svh"
bind shrp_port shrp_chk shrp_chk_inst (.*);
// ========
// Bench
module tb;
  logic        clk_sys;
  logic        rstn;
  logic        sclk;
  logic        chip_select_n;
  logic        command_data_in;
  logic        reply_data_o;
  logic        reply_data_oe_n;
  logic        cmd_valid;
  logic [7:0]  cmd_code;
  logic [7:0]  rd_addr;
  logic [1:0]  rd_index;
  logic [7:0]  rd_data;
  logic        wr_valid;
  logic        wr_ready;
  logic [15:0] wr_data;
  logic        wr_overflow;
  logic        stall;
  logic [15:0] cq[$];
  logic [15:0] wq[$];
  int          errors;
  int          checks_done;
  int          seed;
  int          i;
  int          j;

  shrp_port shrp_port_inst (.*);
  shrp_host shrp_host_inst (.*);

  always #12.5 clk_sys = ~clk_sys;
  always_comb rd_data = rd_addr ^ {rd_index, 6'h2A};
  always @(negedge clk_sys) wr_ready <= !stall && $random(seed) % 3 != 0;

  task chk(input logic [15:0] seen, exp, input string nm);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task wrap_up();
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // Look mid-cycle, once wr_ready for the next edge has settled
  always @(negedge clk_sys) begin
    #1;
    if (cmd_valid === 1'b1)
      chk({8'h00, cmd_code}, cq.size() ? cq.pop_front() : 'x, "code");
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      chk(wr_data, wq.size() ? wq.pop_front() : 'x, "wdata");
  end

  task send(input logic [7:0] ac, input int n, nb, input logic idle,
            input int gap);
    logic [39:0] v;
    logic [7:0]  b;
    int          k;
    v = {ac, 32'h0000_0000};
    if (nb >= 8)
      cq.push_back({8'h00, ac});
    for (k = 0; k < n; k++) begin
      b = 8'($random(seed));
      v[31-8*k -: 8] = b;
      if (ac[7:6] == 2'h1 && nb >= 16 + 8 * k &&
          (!stall || wq.size() < `SHRP_FIFO_D))
        wq.push_back({ac, b});
    end
    shrp_host_inst.frame(v, nb, idle, gap);
    if (ac[7:6] == 2'h2)
      for (k = 0; k < n; k++)
        chk(shrp_host_inst.rx[8*n-1-8*k -: 8], ac ^ {k[1:0], 6'h2A}, "rdata");
  endtask : send

  task drain();
    for (i = 0; i < 2000 && (wq.size() || cq.size()); i++)
      @(posedge clk_sys);
    if (wq.size() || cq.size()) begin
      errors++;
      wrap_up();
    end
  endtask : drain

  initial begin
    clk_sys = 1'b0;
    rstn = 1'b0;
    stall = 1'b0;
    wr_ready = 1'b0;
    seed = 93;
    errors = 0;
    checks_done = 0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys) rstn = 1'b1;
    #107;
    // Every kind and length; spare bits after command-only are ignored
    for (i = 0; i < 4; i++)
      for (j = 0; j < 4; j++)
        send({i[1:0], j[1:0], 4'h5}, j + 1, 16 + 8 * j, j[0], 100 * i);
    send(8'h50, 2, 5, 1'b0, 0);
    send(8'h50, 2, 20, 1'b1, 0);
    drain();
    // Stall the user side until the buffer refuses
    stall = 1'b1;
    for (j = 0; j < 3; j++)
      send(8'h70, 4, 40, 1'b0, 0);
    chk({15'h0000, wr_overflow}, 16'h0001, "ovf");
    stall = 1'b0;
    send(8'h00, 0, 8, 1'b1, 0);
    chk({15'h0000, wr_overflow}, 16'h0000, "ovf");
    drain();
    wrap_up();
  end
endmodule : tb
